// ### aucr_config_bank.v
// Upper configuration register bank of a quad converter: patterns, stream, channel and rate controls.
// Assumes a serial control port decoder issuing single-cycle writes and reading data combinationally.
`include "aucr_defines.vh"

module aucr_config_bank (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire CLK_EN,
  input wire [12:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg [15:0] USER_PATTERN1,
  output reg [15:0] USER_PATTERN2,
  output reg LSB_FIRST,
  output reg [2:0] LANE_MODE,
  output reg FRAME_2X,
  output reg [1:0] WORD_WIDTH,
  output reg [3:0] CHAN_POWER_DOWN,
  output reg [3:0] CHAN_OUT_RESET,
  output reg DATA_CLOCK_OUTPUT_POWER_DOWN,
  output reg FRAME_CLOCK_OUTPUT_POWER_DOWN,
  output reg RATE_OVERRIDE_EN,
  output reg [7:0] RATE_CAPABILITY_MSPS,
  output reg SDIO_PULLDOWN_EN,
  output reg COMMON_MODE_OUTPUT_POWER_DOWN,
  output reg SYNC_ENABLE,
  output reg SYNC_NEXT_ONLY
);

  reg rst_meta;
  reg rst_sync_n;
  reg [7:0] chan_index_a;
  reg [7:0] chan_index_b;
  reg [7:0] stream_ctrl;
  reg [7:0] rate_ovr;
  reg [7:0] io_pulldown;
  reg [7:0] io_common_mode;
  reg [7:0] sync_ctrl;
  reg [7:0] next_msps;
  reg [7:0] local_rdata;
  wire wr;
  wire [5:0] chan_sel;
  integer i;

  // Release reset through two flops so every flop leaves reset on the same edge
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  assign wr = REG_WR & CLK_EN;
  // Data channel bits come from the second index; host keeps the first equal
  assign chan_sel = chan_index_b[5:0];

  // Global registers ignore the channel selection
  always @(posedge CORE_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      USER_PATTERN1 <= {`AUCR_RST_PATT, `AUCR_RST_PATT};
      USER_PATTERN2 <= {`AUCR_RST_PATT, `AUCR_RST_PATT};
      stream_ctrl <= `AUCR_RST_STREAM_CTRL;
      rate_ovr <= `AUCR_RST_RATE_OVR;
      io_pulldown <= `AUCR_RST_IO;
      io_common_mode <= `AUCR_RST_IO;
      sync_ctrl <= `AUCR_RST_SYNC;
      chan_index_a <= `AUCR_RST_CHAN_INDEX;
      chan_index_b <= `AUCR_RST_CHAN_INDEX_B;
    end else if (wr) begin
      case (REG_ADDR)
        `AUCR_ADDR_PATT1_LOW: USER_PATTERN1[7:0] <= REG_WDATA;
        `AUCR_ADDR_PATT1_HIGH: USER_PATTERN1[15:8] <= REG_WDATA;
        `AUCR_ADDR_PATT2_LOW: USER_PATTERN2[7:0] <= REG_WDATA;
        `AUCR_ADDR_PATT2_HIGH: USER_PATTERN2[15:8] <= REG_WDATA;
        `AUCR_ADDR_STREAM_CTRL: stream_ctrl <= REG_WDATA & `AUCR_MASK_STREAM_CTRL;
        `AUCR_ADDR_RATE_OVR: rate_ovr <= REG_WDATA & `AUCR_MASK_RATE_OVR;
        `AUCR_ADDR_IO_PULLDOWN: io_pulldown <= {7'h00, REG_WDATA[`AUCR_BIT_PULLDOWN_OFF]};
        `AUCR_ADDR_IO_COMMON_MODE: io_common_mode <= REG_WDATA & 8'h08;
        `AUCR_ADDR_SYNC: sync_ctrl <= REG_WDATA & 8'h03;
        `AUCR_ADDR_CHAN_INDEX_A: chan_index_a <= REG_WDATA & `AUCR_MASK_CHAN_INDEX_A;
        `AUCR_ADDR_CHAN_INDEX_B: chan_index_b <= REG_WDATA & `AUCR_MASK_CHAN_INDEX_B;
        default: ;
      endcase
    end
  end

  // Stream fields act one edge after being written, without a transfer
  always @(posedge CORE_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      LSB_FIRST <= 1'b0;
      LANE_MODE <= 3'h3;
      FRAME_2X <= 1'b0;
      WORD_WIDTH <= 2'h0;
      SDIO_PULLDOWN_EN <= 1'b1;
      COMMON_MODE_OUTPUT_POWER_DOWN <= 1'b0;
      SYNC_ENABLE <= 1'b0;
      SYNC_NEXT_ONLY <= 1'b0;
    end else if (CLK_EN) begin
      LSB_FIRST <= stream_ctrl[`AUCR_BIT_LSB_FIRST];
      LANE_MODE <= stream_ctrl[`AUCR_BIT_LANE_MSB:`AUCR_BIT_LANE_LSB];
      FRAME_2X <= stream_ctrl[`AUCR_BIT_FRAME_2X];
      WORD_WIDTH <= stream_ctrl[`AUCR_BIT_WIDTH_MSB:0];
      SDIO_PULLDOWN_EN <= ~io_pulldown[`AUCR_BIT_PULLDOWN_OFF];
      COMMON_MODE_OUTPUT_POWER_DOWN <= io_common_mode[`AUCR_BIT_CM_POWER_DOWN];
      SYNC_ENABLE <= sync_ctrl[`AUCR_BIT_SYNC_ENABLE];
      SYNC_NEXT_ONLY <= sync_ctrl[`AUCR_BIT_SYNC_NEXT];
    end
  end

  // Rate decode; the unused code 111 is held at full rate rather than left undefined
  always @* begin
    case (rate_ovr[`AUCR_BIT_RATE_MSB:0])
      3'h0: next_msps = `AUCR_MSPS_20;
      3'h1: next_msps = `AUCR_MSPS_40;
      3'h2: next_msps = `AUCR_MSPS_50;
      3'h3: next_msps = `AUCR_MSPS_65;
      3'h4: next_msps = `AUCR_MSPS_80;
      3'h5: next_msps = `AUCR_MSPS_105;
      3'h6: next_msps = `AUCR_MSPS_125;
      default: next_msps = `AUCR_MSPS_125;
    endcase
  end

  // Override reaches the core only on a transfer write
  always @(posedge CORE_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      RATE_OVERRIDE_EN <= 1'b0;
      RATE_CAPABILITY_MSPS <= `AUCR_MSPS_125;
    end else if (wr && REG_ADDR == `AUCR_ADDR_TRANSFER && REG_WDATA[`AUCR_BIT_TRANSFER]) begin
      RATE_OVERRIDE_EN <= rate_ovr[`AUCR_BIT_RATE_ENABLE];
      RATE_CAPABILITY_MSPS <= rate_ovr[`AUCR_BIT_RATE_ENABLE] ? next_msps : `AUCR_MSPS_125;
    end
  end

  // Per data channel local bits, written only when selected
  genvar g;
  generate
    for (g = 0; g < `AUCR_DATA_CHANNELS; g = g + 1) begin : data_chan
      always @(posedge CORE_CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          CHAN_POWER_DOWN[g] <= 1'b0;
          CHAN_OUT_RESET[g] <= 1'b0;
        end else if (wr && REG_ADDR == `AUCR_ADDR_CHAN_POWER && chan_sel[g]) begin
          CHAN_POWER_DOWN[g] <= REG_WDATA[`AUCR_BIT_POWER_DOWN];
          CHAN_OUT_RESET[g] <= REG_WDATA[`AUCR_BIT_OUT_RESET];
        end
      end
    end
  endgenerate

  // Clock outputs keep only the power-down bit; no output reset applies to them
  always @(posedge CORE_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      DATA_CLOCK_OUTPUT_POWER_DOWN <= 1'b0;
      FRAME_CLOCK_OUTPUT_POWER_DOWN <= 1'b0;
    end else if (wr && REG_ADDR == `AUCR_ADDR_CHAN_POWER) begin
      if (chan_sel[4])
        DATA_CLOCK_OUTPUT_POWER_DOWN <= REG_WDATA[`AUCR_BIT_POWER_DOWN];
      if (chan_sel[5])
        FRAME_CLOCK_OUTPUT_POWER_DOWN <= REG_WDATA[`AUCR_BIT_POWER_DOWN];
    end
  end

  // Local readback shows the lowest selected channel
  always @* begin
    local_rdata = 8'h00;
    if (chan_sel[5])
      local_rdata = {7'h00, FRAME_CLOCK_OUTPUT_POWER_DOWN};
    if (chan_sel[4])
      local_rdata = {7'h00, DATA_CLOCK_OUTPUT_POWER_DOWN};
    for (i = `AUCR_DATA_CHANNELS - 1; i >= 0; i = i - 1) begin
      if (chan_sel[i])
        local_rdata = {6'h00, CHAN_OUT_RESET[i], CHAN_POWER_DOWN[i]};
    end
  end

  always @* begin
    case (REG_ADDR)
      `AUCR_ADDR_CHAN_INDEX_A: REG_RDATA = chan_index_a;
      `AUCR_ADDR_CHAN_INDEX_B: REG_RDATA = chan_index_b;
      `AUCR_ADDR_PATT1_LOW: REG_RDATA = USER_PATTERN1[7:0];
      `AUCR_ADDR_PATT1_HIGH: REG_RDATA = USER_PATTERN1[15:8];
      `AUCR_ADDR_PATT2_LOW: REG_RDATA = USER_PATTERN2[7:0];
      `AUCR_ADDR_PATT2_HIGH: REG_RDATA = USER_PATTERN2[15:8];
      `AUCR_ADDR_STREAM_CTRL: REG_RDATA = stream_ctrl;
      `AUCR_ADDR_CHAN_POWER: REG_RDATA = local_rdata;
      `AUCR_ADDR_RATE_OVR: REG_RDATA = rate_ovr;
      `AUCR_ADDR_IO_PULLDOWN: REG_RDATA = io_pulldown;
      `AUCR_ADDR_IO_COMMON_MODE: REG_RDATA = io_common_mode;
      `AUCR_ADDR_SYNC: REG_RDATA = sync_ctrl;
      default: REG_RDATA = 8'h00;
    endcase
  end

endmodule

// ### aucr_config_bank_chk.sv
// Port checker for the upper configuration bank.
// Assumes CLK_EN stays high while derived outputs settle.
module aucr_config_bank_chk (
  input logic CORE_CLK, ARST_N, CLK_EN, REG_WR,
  input logic [12:0] REG_ADDR,
  input logic [7:0] REG_WDATA, REG_RDATA, RATE_CAPABILITY_MSPS,
  input logic [15:0] USER_PATTERN1, USER_PATTERN2,
  input logic LSB_FIRST, SDIO_PULLDOWN_EN, COMMON_MODE_OUTPUT_POWER_DOWN,
  input logic RATE_OVERRIDE_EN, SYNC_ENABLE, SYNC_NEXT_ONLY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  logic wr;
  assign wr = REG_WR && CLK_EN;
  chk_patt1_low: assert property (wr && REG_ADDR == 13'h019 |=> USER_PATTERN1[7:0] == $past(REG_WDATA))
    else $error("pattern 1 low byte not stored");
  chk_patt2_high: assert property (wr && REG_ADDR == 13'h01c |=> USER_PATTERN2[15:8] == $past(REG_WDATA))
    else $error("pattern 2 high byte not stored");
  chk_lsb_first: assert property (wr && REG_ADDR == 13'h021 |=> ##1 LSB_FIRST == $past(REG_WDATA[7], 2))
    else $error("lane order bit wrong");
  chk_rate_hold: assert property (!(wr && REG_ADDR == 13'h0ff && REG_WDATA[0]) |=> $stable(RATE_CAPABILITY_MSPS) && $stable(RATE_OVERRIDE_EN))
    else $error("rate outputs moved without transfer");
  chk_pulldown_off: assert property (wr && REG_ADDR == 13'h101 |=> ##1 SDIO_PULLDOWN_EN == !$past(REG_WDATA[0], 2))
    else $error("pull-down enable wrong");
  chk_cm_power: assert property (wr && REG_ADDR == 13'h102 |=> ##1 COMMON_MODE_OUTPUT_POWER_DOWN == $past(REG_WDATA[3], 2))
    else $error("common-mode power-down wrong");
  chk_sync_bits: assert property (wr && REG_ADDR == 13'h109 |=> ##1 {SYNC_NEXT_ONLY, SYNC_ENABLE} == $past(REG_WDATA[1:0], 2))
    else $error("sync bits wrong");
  chk_freeze_hold: assert property (!CLK_EN |=> $stable(USER_PATTERN1) && $stable(USER_PATTERN2))
    else $error("pattern moved while frozen");
  chk_transfer_read: assert property (REG_ADDR == 13'h0ff |-> REG_RDATA == 8'h00)
    else $error("transfer register read nonzero");
endmodule
bind aucr_config_bank aucr_config_bank_chk i_aucr_config_bank_chk (
  .CORE_CLK(CORE_CLK),
  .ARST_N(ARST_N),
  .CLK_EN(CLK_EN),
  .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA),
  .RATE_CAPABILITY_MSPS(RATE_CAPABILITY_MSPS),
  .USER_PATTERN1(USER_PATTERN1),
  .USER_PATTERN2(USER_PATTERN2),
  .LSB_FIRST(LSB_FIRST),
  .SDIO_PULLDOWN_EN(SDIO_PULLDOWN_EN),
  .COMMON_MODE_OUTPUT_POWER_DOWN(COMMON_MODE_OUTPUT_POWER_DOWN),
  .RATE_OVERRIDE_EN(RATE_OVERRIDE_EN),
  .SYNC_ENABLE(SYNC_ENABLE),
  .SYNC_NEXT_ONLY(SYNC_NEXT_ONLY)
);

// ### aucr_config_bank_tb.sv
// Self-checking bench for the upper configuration bank.
// Assumes the bank and its checker compiled first.
module aucr_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 0, ARST_N = 0, CLK_EN = 1, REG_WR = 0;
  logic [12:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, REG_RDATA, RATE_CAPABILITY_MSPS, d;
  logic [15:0] USER_PATTERN1, USER_PATTERN2, got;
  logic LSB_FIRST, FRAME_2X, DATA_CLOCK_OUTPUT_POWER_DOWN, FRAME_CLOCK_OUTPUT_POWER_DOWN;
  logic RATE_OVERRIDE_EN, SDIO_PULLDOWN_EN, COMMON_MODE_OUTPUT_POWER_DOWN, SYNC_ENABLE;
  logic SYNC_NEXT_ONLY;
  logic [2:0] LANE_MODE;
  logic [1:0] WORD_WIDTH;
  logic [3:0] CHAN_POWER_DOWN, CHAN_OUT_RESET;
  logic [18:0] exp_q[$];
  logic [7:0] mtab[8] = '{8'h14, 8'h28, 8'h32, 8'h41, 8'h50, 8'h69, 8'h7d, 8'h7d};
  int bad_count = 0, checked = 0, seed = 32'h398250e5, i;
  always #5 CORE_CLK = ~CORE_CLK;
  aucr_config_bank i_aucr_config_bank (
    .CORE_CLK(CORE_CLK),
    .ARST_N(ARST_N),
    .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .USER_PATTERN1(USER_PATTERN1),
    .USER_PATTERN2(USER_PATTERN2),
    .LSB_FIRST(LSB_FIRST),
    .LANE_MODE(LANE_MODE),
    .FRAME_2X(FRAME_2X),
    .WORD_WIDTH(WORD_WIDTH),
    .CHAN_POWER_DOWN(CHAN_POWER_DOWN),
    .CHAN_OUT_RESET(CHAN_OUT_RESET),
    .DATA_CLOCK_OUTPUT_POWER_DOWN(DATA_CLOCK_OUTPUT_POWER_DOWN),
    .FRAME_CLOCK_OUTPUT_POWER_DOWN(FRAME_CLOCK_OUTPUT_POWER_DOWN),
    .RATE_OVERRIDE_EN(RATE_OVERRIDE_EN),
    .RATE_CAPABILITY_MSPS(RATE_CAPABILITY_MSPS),
    .SDIO_PULLDOWN_EN(SDIO_PULLDOWN_EN),
    .COMMON_MODE_OUTPUT_POWER_DOWN(COMMON_MODE_OUTPUT_POWER_DOWN),
    .SYNC_ENABLE(SYNC_ENABLE),
    .SYNC_NEXT_ONLY(SYNC_NEXT_ONLY)
  );
  // Strobe left high so back-to-back writes assign it once per edge
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(negedge CORE_CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1;
  endtask
  task automatic ck(input logic [2:0] s, input logic [12:0] a, input logic [15:0] e);
    @(negedge CORE_CLK);
    REG_WR = 0;
    REG_ADDR = a;
    exp_q.push_back({s, e});
  endtask
  // Derived outputs lag the write by one extra edge
  task automatic idle();
    repeat (3) begin
      @(negedge CORE_CLK);
      REG_WR = 0;
    end
  endtask
  task automatic conclude();
    $display("TB: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge CORE_CLK) if (exp_q.size() > 0) begin
    case (exp_q[0][18:16])
      0: got = {8'h00, REG_RDATA};
      1: got = USER_PATTERN1;
      2: got = USER_PATTERN2;
      3: got = {7'h00, RATE_OVERRIDE_EN, RATE_CAPABILITY_MSPS};
      4: got = {6'h00, CHAN_POWER_DOWN, CHAN_OUT_RESET, DATA_CLOCK_OUTPUT_POWER_DOWN,
                FRAME_CLOCK_OUTPUT_POWER_DOWN};
      default: got = {5'h00, LSB_FIRST, LANE_MODE, FRAME_2X, WORD_WIDTH, SDIO_PULLDOWN_EN,
                      COMMON_MODE_OUTPUT_POWER_DOWN, SYNC_NEXT_ONLY, SYNC_ENABLE};
    endcase
    checked++;
    if (got !== exp_q[0][15:0]) begin
      bad_count++;
      $display("CHECK FAILED %0t sel %0d got %h exp %h", $time, exp_q[0][18:16], got, exp_q[0][15:0]);
    end
    void'(exp_q.pop_front());
  end
  initial begin
    repeat (2000) @(posedge CORE_CLK);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge CORE_CLK);
    ARST_N = 1;
    repeat (2) @(negedge CORE_CLK);
    ck(1, 13'h021, 16'h0000);
    ck(2, 13'h021, 16'h0000);
    ck(0, 13'h021, 16'h0030);
    ck(5, 13'h022, 16'h0188);
    ck(3, 13'h1ff, 16'h007d);
    ck(0, 13'h1ff, 16'h0000);
    ck(0, 13'h004, 16'h000f);
    ck(0, 13'h005, 16'h003f);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(13'h019, d);
      wr(13'h01a, ~d);
      wr(13'h01b, d ^ 8'h5a);
      wr(13'h01c, d + 8'h01);
      ck(1, 13'h01c, {~d, d});
      ck(2, 13'h01c, {d + 8'h01, d ^ 8'h5a});
      ck(0, 13'h01c, {8'h00, d + 8'h01});
    end
    wr(13'h021, 8'hff);
    wr(13'h101, 8'h01);
    wr(13'h102, 8'hff);
    wr(13'h109, 8'hff);
    idle();
    ck(5, 13'h021, 16'h07f7);
    ck(0, 13'h102, 16'h0008);
    ck(0, 13'h109, 16'h0003);
    ck(0, 13'h101, 16'h0001);
    for (i = 0; i < 8; i++) begin
      wr(13'h100, 8'h40 | i[7:0]);
      ck(3, 13'h100, i > 0 ? {8'h01, mtab[i - 1]} : 16'h007d);
      wr(13'h0ff, 8'h01);
      ck(3, 13'h100, {8'h01, mtab[i]});
    end
    wr(13'h100, 8'hff);
    ck(0, 13'h100, 16'h0047);
    wr(13'h100, 8'h03);
    wr(13'h0ff, 8'h01);
    ck(3, 13'h0ff, 16'h007d);
    wr(13'h004, 8'h02);
    wr(13'h005, 8'h02);
    wr(13'h022, 8'h03);
    ck(4, 13'h022, 16'h0088);
    ck(0, 13'h022, 16'h0003);
    wr(13'h004, 8'h00);
    wr(13'h005, 8'h10);
    wr(13'h022, 8'h03);
    wr(13'h019, 8'h3c);
    ck(4, 13'h019, 16'h008a);
    ck(0, 13'h019, 16'h003c);
    wr(13'h004, 8'h00);
    wr(13'h005, 8'h20);
    wr(13'h022, 8'h01);
    ck(4, 13'h005, 16'h008b);
    ck(0, 13'h005, 16'h0020);
    ck(0, 13'h022, 16'h0001);
    @(negedge CORE_CLK);
    CLK_EN = 0;
    wr(13'h019, 8'hc3);
    ck(0, 13'h019, 16'h003c);
    CLK_EN = 1;
    idle();
    conclude();
  end
endmodule

// ### aucr_defines.vh
// Register offsets, field positions and reset values of the upper configuration bank.
// Assumes 13-bit register addresses from the serial control port decoder.
`ifndef AUCR_DEFINES_VH
`define AUCR_DEFINES_VH
`define AUCR_ADDR_CHAN_INDEX_A 13'h004
`define AUCR_ADDR_CHAN_INDEX_B 13'h005
`define AUCR_ADDR_PATT1_LOW 13'h019
`define AUCR_ADDR_PATT1_HIGH 13'h01a
`define AUCR_ADDR_PATT2_LOW 13'h01b
`define AUCR_ADDR_PATT2_HIGH 13'h01c
`define AUCR_ADDR_STREAM_CTRL 13'h021
`define AUCR_ADDR_CHAN_POWER 13'h022
`define AUCR_ADDR_TRANSFER 13'h0ff
`define AUCR_ADDR_RATE_OVR 13'h100
`define AUCR_ADDR_IO_PULLDOWN 13'h101
`define AUCR_ADDR_IO_COMMON_MODE 13'h102
`define AUCR_ADDR_SYNC 13'h109
`define AUCR_RST_PATT 8'h00
`define AUCR_RST_STREAM_CTRL 8'h30
`define AUCR_RST_CHAN_POWER 2'h0
`define AUCR_RST_RATE_OVR 8'h00
`define AUCR_RST_IO 8'h00
`define AUCR_RST_SYNC 8'h00
`define AUCR_RST_CHAN_INDEX 8'h0f
`define AUCR_RST_CHAN_INDEX_B 8'h3f
`define AUCR_MASK_STREAM_CTRL 8'hf7
`define AUCR_MASK_RATE_OVR 8'h47
`define AUCR_MASK_CHAN_INDEX_A 8'h0f
`define AUCR_MASK_CHAN_INDEX_B 8'h3f
`define AUCR_BIT_LSB_FIRST 7
`define AUCR_BIT_LANE_MSB 6
`define AUCR_BIT_LANE_LSB 4
`define AUCR_BIT_FRAME_2X 2
`define AUCR_BIT_WIDTH_MSB 1
`define AUCR_BIT_POWER_DOWN 0
`define AUCR_BIT_OUT_RESET 1
`define AUCR_BIT_RATE_ENABLE 6
`define AUCR_BIT_RATE_MSB 2
`define AUCR_BIT_TRANSFER 0
`define AUCR_BIT_PULLDOWN_OFF 0
`define AUCR_BIT_CM_POWER_DOWN 3
`define AUCR_BIT_SYNC_ENABLE 0
`define AUCR_BIT_SYNC_NEXT 1
`define AUCR_DATA_CHANNELS 4
`define AUCR_CLOCK_CHANNELS 2
`define AUCR_MSPS_20 8'h14
`define AUCR_MSPS_40 8'h28
`define AUCR_MSPS_50 8'h32
`define AUCR_MSPS_65 8'h41
`define AUCR_MSPS_80 8'h50
`define AUCR_MSPS_105 8'h69
`define AUCR_MSPS_125 8'h7d
`endif
